// ==== ethernet_rx_address_filter.sv ====
// Receive front end: MII capture, address filter, pad strip, CRC check
// Behaviour
// - Pad stripping happens only while feature control bit 0 is one.
// - A stripped frame loses both its pad bytes and its checksum.
// - Strip only when the length field is below 46; otherwise pass unchanged.
// - Checksum is checked over every received byte, pad included.
// - Checksum mismatch sets the checksum error bit of the descriptor.
// - First destination bit zero means unicast, one means multicast.
// - Destination all ones means broadcast.
// - Unicast needs all six bytes equal; first byte against address bits 7:0.
// - Disable-unicast bit 13 rejects unicast unless promiscuous or external filter bit 1 is set.
// - Non-broadcast multicast accepted only on a hash hit, unless promiscuous or external filter bit 1 is set.
// - Broadcast accepted unless disable-broadcast bit 14 is set.
// - Promiscuous bit 15 accepts every frame not externally rejected, ignoring both disable bits.
// - Transfer request starts at the watermark, or at frame end if the watermark is not reached; reset code 01 is 64 bytes.
// - Runt accept lets frames of 12 bytes or more through.
// - Accepted frames carry match flags: 22 station, 21 hash, 20 broadcast.
// - Broadcast frames set only the broadcast flag, never the hash flag.
// - Match flags stay clear in the 16-bit descriptor style.
// - External reject low inside the protect window rejects the frame.
// - A register sets the length of the protect window.
// - Frames under 64 bytes are discarded by default.
`timescale 1ns/1ps
module ethernet_rx_address_filter
  import eth_rx_pkg::*;
#(
  parameter int AW = eth_rx_pkg::ADDR_W
) (
  input wire logic ref_clk, // System clock, 40 MHz
  input wire logic rst, // Sync reset, active high
  input wire logic mii_rx_clk, // MII receive clock, sampled
  input wire logic mii_rx_dv, // MII data valid
  input wire logic [3:0] mii_rxd, // MII receive nibble
  input wire logic external_reject_n, // External filter reject, low
  input wire logic [AW-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [AW-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output eth_rx_pkg::rx_beat_t rx_beat, // Byte toward receive FIFO
  output logic desc_valid, // Frame end, descriptor pulse
  output logic [31:0] rx_descriptor_word1, // Frame status word
  output logic dma_request // Watermark reached or frame end
);
  import eth_rx_pkg::*;

  if (AW < ADDR_W) begin : g_bad_aw
    $error("AW too narrow for register map");
  end

  // Synchronisers for the MII pins and the external reject input
  logic [1:0] rck_s, dv_s, rej_s;
  logic [3:0] d1_s, d2_s;
  logic rck_prev_q;
  always_ff @(posedge ref_clk) begin
    rck_s <= {rck_s[0], mii_rx_clk};
    dv_s <= {dv_s[0], mii_rx_dv};
    rej_s <= {rej_s[0], external_reject_n};
    d1_s <= mii_rxd;
    d2_s <= d1_s;
    rck_prev_q <= rck_s[1];
  end
  // Falling edge: data is mid-bit there, safe from the launch edge
  logic fall;
  assign fall = rck_prev_q && !rck_s[1];

  // Registers
  logic strip_en_q, ext_filter_en_q, dis_uni_q, dis_bc_q, promisc_q, runt_en_q;
  logic [47:0] station_address;
  logic [63:0] multicast_hash_filter;
  logic [1:0] rx_fifo_watermark;
  logic [15:0] protect_q;
  logic [7:0] descriptor_style;

  // Frame state
  rx_state_t st_q;
  logic half_q, byte_stb_q, strip_fr_q, len_ok_q, ext_rej_q;
  logic [3:0] lo_q;
  logic [7:0] byte_q;
  logic [15:0] cnt_q, len_q, out_cnt_q;
  logic [47:0] da_q;
  logic [5:0] hidx_q;
  logic [31:0] crc_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= S_IDLE;
    end else begin
      unique case (st_q)
        S_IDLE: if (fall && dv_s[1] && d2_s == PRE_NIB) begin
          st_q <= S_SFD;
        end
        // Carrier loss ends the frame even when the link clock stops
        S_SFD: if (!dv_s[1]) begin
          st_q <= S_IDLE;
        end else if (fall && d2_s == SFD_NIB) begin
          st_q <= S_DATA;
        end
        S_DATA: if (!dv_s[1]) begin
          st_q <= S_DONE;
        end
        S_DONE: st_q <= S_IDLE;
      endcase
    end
  end

  // Nibble pairing, low nibble first
  always_ff @(posedge ref_clk) begin
    if (rst || st_q != S_DATA) begin
      half_q <= 1'b0;
      lo_q <= 4'h0;
      byte_stb_q <= 1'b0;
      byte_q <= 8'h00;
    end else begin
      byte_stb_q <= fall && dv_s[1] && half_q;
      if (fall && dv_s[1]) begin
        half_q <= !half_q;
        if (half_q) begin
          byte_q <= {d2_s, lo_q};
        end else begin
          lo_q <= d2_s;
        end
      end
    end
  end

  // Checksum over every byte, pad and checksum included
  crc32_byte u_crc (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(st_q == S_IDLE),
    .en(byte_stb_q),
    .data(byte_q),
    .crc_q(crc_q)
  );

  // Header capture
  always_ff @(posedge ref_clk) begin
    if (rst || st_q == S_IDLE) begin
      cnt_q <= 16'h0000;
      len_q <= 16'h0000;
      len_ok_q <= 1'b0;
      da_q <= 48'h000000000000;
      hidx_q <= 6'h00;
      strip_fr_q <= strip_en_q;
    end else if (byte_stb_q) begin
      cnt_q <= cnt_q + 16'h0001;
      if (cnt_q < DA_LEN) begin
        da_q[cnt_q[2:0]*8 +: 8] <= byte_q;
      end
      // Remainder after six address bytes indexes the hash table
      if (cnt_q == DA_LEN) begin
        hidx_q <= crc_q[31:26];
      end
      if (cnt_q == LEN_HI_IDX) begin
        len_q[15:8] <= byte_q;
      end
      if (cnt_q == LEN_LO_IDX) begin
        len_q[7:0] <= byte_q;
        len_ok_q <= 1'b1;
      end
    end
  end

  // External reject honoured only inside the protect window
  always_ff @(posedge ref_clk) begin
    if (rst || st_q == S_IDLE) begin
      ext_rej_q <= 1'b0;
    end else if (st_q == S_DATA && !rej_s[1] && cnt_q < protect_q) begin
      ext_rej_q <= 1'b1;
    end
  end

  // Pad stripping cuts payload after header plus length, checksum too
  logic strip_act, keep;
  logic [16:0] keep_lim;
  assign strip_act = strip_fr_q && len_ok_q && len_q < PAD_LIMIT;
  assign keep_lim = {1'b0, HDR_LEN} + {1'b0, len_q};
  assign keep = !(strip_act && {1'b0, cnt_q} >= keep_lim);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_beat <= '0;
    end else begin
      rx_beat.valid <= byte_stb_q && keep;
      rx_beat.data <= byte_q;
    end
  end

  // Watermark request
  always_ff @(posedge ref_clk) begin
    if (rst || st_q == S_IDLE) begin
      out_cnt_q <= 16'h0000;
      dma_request <= 1'b0;
    end else begin
      if (rx_beat.valid) begin
        out_cnt_q <= out_cnt_q + 16'h0001;
      end
      dma_request <= out_cnt_q >= wm_bytes(rx_fifo_watermark) || st_q == S_DONE;
    end
  end

  // Frame decision
  logic is_mc, is_bc, sta_hit, hash_hit, station_match_flag, hash_match_flag;
  logic broadcast_match_flag;
  logic accept, runt_bad, crc_bad, discard, flags_on;
  always_comb begin
    is_mc = da_q[0];
    is_bc = &da_q;
    sta_hit = !is_mc && da_q == station_address;
    hash_hit = is_mc && !is_bc && multicast_hash_filter[hidx_q];
    station_match_flag = sta_hit && !dis_uni_q;
    broadcast_match_flag = is_bc && !dis_bc_q;
    hash_match_flag = hash_hit;
    accept = (promisc_q || station_match_flag || broadcast_match_flag || hash_match_flag
              || ext_filter_en_q) && !(ext_filter_en_q && ext_rej_q);
    runt_bad = cnt_q < MIN_FRAME && !(runt_en_q && cnt_q >= RUNT_MIN);
    crc_bad = crc_q != CRC_RESIDUE;
    discard = !accept || runt_bad;
    flags_on = descriptor_style != STYLE_RESET;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      desc_valid <= 1'b0;
      rx_descriptor_word1 <= 32'h00000000;
    end else begin
      desc_valid <= st_q == S_DONE;
      if (st_q == S_DONE) begin
        rx_descriptor_word1 <= {16'h0000, cnt_q};
        rx_descriptor_word1[CRC_ERR_BIT] <= crc_bad;
        rx_descriptor_word1[DISCARD_BIT] <= discard;
        rx_descriptor_word1[STA_MATCH_BIT] <= flags_on && !discard && station_match_flag;
        rx_descriptor_word1[HASH_MATCH_BIT] <= flags_on && !discard && hash_match_flag;
        rx_descriptor_word1[BC_MATCH_BIT] <= flags_on && !discard && broadcast_match_flag;
      end
    end
  end

  // Register read view and AXI4-Lite slave
  function automatic logic [31:0] reg_view(input logic [AW-1:0] a);
    logic [31:0] v;
    v = 32'h00000000;
    unique case (a)
      OFF_FEATURE: begin
        v[PAD_STRIP_BIT] = strip_en_q;
        v[EXT_FILTER_BIT] = ext_filter_en_q;
      end
      OFF_MODE: begin
        v[DIS_UNI_BIT] = dis_uni_q;
        v[DIS_BC_BIT] = dis_bc_q;
        v[PROMISC_BIT] = promisc_q;
      end
      OFF_STA_LO: v = station_address[31:0];
      OFF_STA_HI: v[15:0] = station_address[47:32];
      OFF_HASH_LO: v = multicast_hash_filter[31:0];
      OFF_HASH_HI: v = multicast_hash_filter[63:32];
      OFF_FIFO_THR: v[1:0] = rx_fifo_watermark;
      OFF_TEST: v[RUNT_BIT] = runt_en_q;
      OFF_PROTECT: v[15:0] = protect_q;
      OFF_STYLE: v[7:0] = descriptor_style;
      OFF_DESC: v = rx_descriptor_word1;
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [AW-1:0] a);
    return a <= OFF_DESC && a[1:0] == 2'h0;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic aw_full_q, w_full_q, do_wr;
  logic [AW-1:0] aw_q;
  logic [31:0] w_q, wv;
  logic [3:0] ws_q;
  assign do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
  // Process form so register changes re-evaluate the merged value
  always_comb wv = merge(reg_view(aw_q), w_q, ws_q);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_q <= '0;
      w_q <= 32'h00000000;
      ws_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr;
        aw_full_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        w_full_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (mapped(aw_q) && aw_q != OFF_DESC) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strip_en_q <= 1'b0;
      ext_filter_en_q <= 1'b0;
      dis_uni_q <= 1'b0;
      dis_bc_q <= 1'b0;
      promisc_q <= 1'b0;
      runt_en_q <= 1'b0;
      station_address <= 48'h000000000000;
      multicast_hash_filter <= 64'h0000000000000000;
      rx_fifo_watermark <= WM_RESET;
      protect_q <= PROTECT_RESET;
      descriptor_style <= STYLE_RESET;
    end else if (do_wr) begin
      unique case (aw_q)
        OFF_FEATURE: begin
          strip_en_q <= wv[PAD_STRIP_BIT];
          ext_filter_en_q <= wv[EXT_FILTER_BIT];
        end
        OFF_MODE: begin
          dis_uni_q <= wv[DIS_UNI_BIT];
          dis_bc_q <= wv[DIS_BC_BIT];
          promisc_q <= wv[PROMISC_BIT];
        end
        OFF_STA_LO: station_address[31:0] <= wv;
        OFF_STA_HI: station_address[47:32] <= wv[15:0];
        OFF_HASH_LO: multicast_hash_filter[31:0] <= wv;
        OFF_HASH_HI: multicast_hash_filter[63:32] <= wv;
        OFF_FIFO_THR: rx_fifo_watermark <= wv[1:0];
        OFF_TEST: runt_en_q <= wv[RUNT_BIT];
        OFF_PROTECT: protect_q <= wv[15:0];
        OFF_STYLE: descriptor_style <= wv[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= reg_view(s_axi_araddr);
        s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_strip_cut;
    byte_stb_q && strip_act && {1'b0, cnt_q} >= keep_lim |=> !rx_beat.valid;
  endproperty
  a_strip_cut: assert property (p_strip_cut) else $error("stripped byte emitted");

  property p_pass_long;
    byte_stb_q && !(strip_fr_q && len_ok_q && len_q < PAD_LIMIT) |=> rx_beat.valid;
  endproperty
  a_pass_long: assert property (p_pass_long) else $error("unstripped byte lost");

  property p_crc_flag;
    st_q == S_DONE |=> desc_valid && rx_descriptor_word1[CRC_ERR_BIT] == $past(crc_bad);
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("crc error bit wrong");

  property p_bc_only;
    desc_valid && rx_descriptor_word1[BC_MATCH_BIT] |-> !rx_descriptor_word1[HASH_MATCH_BIT];
  endproperty
  a_bc_only: assert property (p_bc_only) else $error("hash flag with broadcast");

  property p_style16;
    desc_valid && descriptor_style == STYLE_RESET
      |-> rx_descriptor_word1[STA_MATCH_BIT:BC_MATCH_BIT] == 3'h0;
  endproperty
  a_style16: assert property (p_style16) else $error("flags in 16-bit style");

  property p_dis_uni;
    st_q == S_DONE && dis_uni_q |=> !rx_descriptor_word1[STA_MATCH_BIT];
  endproperty
  a_dis_uni: assert property (p_dis_uni) else $error("station flag while disabled");

  property p_dis_bc;
    st_q == S_DONE && is_bc && dis_bc_q && !promisc_q && !ext_filter_en_q
      |=> rx_descriptor_word1[DISCARD_BIT];
  endproperty
  a_dis_bc: assert property (p_dis_bc) else $error("broadcast taken while disabled");

  property p_promisc;
    st_q == S_DONE && promisc_q && !ext_rej_q && !runt_bad
      |=> !rx_descriptor_word1[DISCARD_BIT];
  endproperty
  a_promisc: assert property (p_promisc) else $error("promiscuous frame dropped");

  property p_runt;
    st_q == S_DONE && cnt_q < MIN_FRAME && !runt_en_q |=> rx_descriptor_word1[DISCARD_BIT];
  endproperty
  a_runt: assert property (p_runt) else $error("short frame kept");

  property p_wm_level;
    st_q == S_DATA && out_cnt_q >= wm_bytes(rx_fifo_watermark) |=> dma_request;
  endproperty
  a_wm_level: assert property (p_wm_level) else $error("watermark request missing");
endmodule

// ==== eth_rx_pkg.sv ====
// Shared constants and types for the receive address filter
package eth_rx_pkg;
  localparam int ADDR_W = 6;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_FEATURE = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_MODE = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_STA_LO = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_STA_HI = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_HASH_LO = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_HASH_HI = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_FIFO_THR = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_TEST = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_PROTECT = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_STYLE = 6'h24;
  localparam logic [ADDR_W-1:0] OFF_DESC = 6'h28;
  // Field positions
  localparam int PAD_STRIP_BIT = 0;
  localparam int EXT_FILTER_BIT = 1;
  localparam int DIS_UNI_BIT = 13;
  localparam int DIS_BC_BIT = 14;
  localparam int PROMISC_BIT = 15;
  localparam int RUNT_BIT = 0;
  localparam int STA_MATCH_BIT = 22;
  localparam int HASH_MATCH_BIT = 21;
  localparam int BC_MATCH_BIT = 20;
  localparam int CRC_ERR_BIT = 27;
  localparam int DISCARD_BIT = 30;
  // Reset values
  localparam logic [1:0] WM_RESET = 2'h1;
  localparam logic [15:0] PROTECT_RESET = 16'h0040;
  localparam logic [7:0] STYLE_RESET = 8'h00;
  // Frame constants (byte counts, nibble codes, CRC values) and response codes
  localparam logic [15:0] MIN_FRAME = 16'h0040;
  localparam logic [15:0] RUNT_MIN = 16'h000C;
  localparam logic [15:0] PAD_LIMIT = 16'h002E;
  localparam logic [15:0] HDR_LEN = 16'h000E;
  localparam logic [15:0] DA_LEN = 16'h0006;
  localparam logic [15:0] LEN_HI_IDX = 16'h000C;
  localparam logic [15:0] LEN_LO_IDX = 16'h000D;
  localparam logic [3:0] PRE_NIB = 4'h5;
  localparam logic [3:0] SFD_NIB = 4'hD;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SFD = 2'b01,
    S_DATA = 2'b10,
    S_DONE = 2'b11
  } rx_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_beat_t;

  // Watermark code to byte fill level
  function automatic logic [15:0] wm_bytes(input logic [1:0] code);
    unique case (code)
      2'h0: wm_bytes = 16'h0010;
      2'h1: wm_bytes = 16'h0040;
      2'h2: wm_bytes = 16'h0080;
      2'h3: wm_bytes = 16'h0100;
    endcase
  endfunction
endpackage

// ==== crc32_byte.sv ====
// Byte-serial reflected CRC-32 engine
`timescale 1ns/1ps
module crc32_byte
  import eth_rx_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic rst, // Sync reset, active high
  input wire logic clear, // Reload initial value
  input wire logic en, // One byte this cycle
  input wire logic [7:0] data, // Byte, LSB first on wire
  output logic [31:0] crc_q // Running remainder
);
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (rst || clear) begin
      crc_q <= CRC_INIT;
    end else if (en) begin
      crc_q <= crc_step(crc_q, data);
    end
  end
endmodule

// ==== mii_phy_model.sv ====
// Behavioural PHY that sends MII receive frames
`timescale 1ns/1ps
module mii_phy_model (
  output logic mii_rx_clk, // Link clock, still between frames
  output logic mii_rx_dv, // Data valid
  output logic [3:0] mii_rxd // Receive nibble
);
  import eth_rx_pkg::*;
  logic [7:0] fb [0:99];
  initial begin
    mii_rx_clk = 1'b0;
    mii_rx_dv = 1'b0;
    mii_rxd = 4'hA;
  end
  // Data set while clock low, so it is stable at the sampling fall
  task automatic nib(input logic [3:0] v);
    mii_rxd = v;
    mii_rx_dv = 1'b1;
    #50 mii_rx_clk = 1'b1;
    #100 mii_rx_clk = 1'b0;
    #50;
  endtask
  task automatic send(input logic [47:0] da, input logic [15:0] lf, input int n, input bit bad);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < n; i++) begin
      fb[i] = i < 6 ? da[8*i+:8] : i == 12 ? lf[15:8] : i == 13 ? lf[7:0] : i < 12 ? 8'h11 : 8'h00;
      c = c ^ {24'h0, fb[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
      end
    end
    c = ~c ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) begin
      fb[n+i] = c[8*i+:8];
    end
    // Offset keeps every pin change clear of the sampling clock edge
    #5;
    for (int i = 0; i < 15; i++) begin
      nib(PRE_NIB);
    end
    nib(SFD_NIB);
    for (int i = 0; i < n + 4; i++) begin
      nib(fb[i][3:0]);
      nib(fb[i][7:4]);
    end
    mii_rx_dv = 1'b0;
    // Released line shows no stale nibble
    mii_rxd = ~mii_rxd;
    #400;
  endtask
endmodule

// ==== tb_top.sv ====
// Self-checking testbench of the receive address filter
`timescale 1ns/1ps
module tb_top;
  import eth_rx_pkg::*;
  localparam logic [47:0] STA = 48'hA5A4A3A2A1A0;
  localparam logic [47:0] BC = 48'hFFFFFFFFFFFF;
  localparam logic [31:0] F_ST = 32'h1 << STA_MATCH_BIT;
  localparam logic [31:0] F_HA = 32'h1 << HASH_MATCH_BIT;
  localparam logic [31:0] F_BC = 32'h1 << BC_MATCH_BIT;
  localparam logic [31:0] F_ER = 32'h1 << CRC_ERR_BIT;
  localparam logic [31:0] F_DI = 32'h1 << DISCARD_BIT;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic mii_rx_clk, mii_rx_dv, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, desc_valid, dma_request;
  logic external_reject_n = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] mii_rxd;
  logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rx_descriptor_word1, desc_q;
  logic [7:0] b13;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  rx_beat_t rx_beat;
  int errors = 0, checks = 0, seen = 0, beats = 0, wm_at = -1;
  always #12.5 ref_clk = ~ref_clk;
  mii_phy_model phy (.mii_rx_clk, .mii_rx_dv, .mii_rxd);
  ethernet_rx_address_filter DUT (.ref_clk, .rst, .mii_rx_clk, .mii_rx_dv, .mii_rxd,
    .external_reject_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_beat, .desc_valid,
    .rx_descriptor_word1, .dma_request);
  always @(posedge ref_clk) begin
    if (rx_beat.valid === 1'b1) begin
      if (beats == 13) b13 = rx_beat.data;
      beats++;
    end
    if (dma_request === 1'b1 && wm_at < 0) wm_at = beats;
    if (desc_valid === 1'b1) begin
      desc_q = rx_descriptor_word1;
      seen++;
    end
  end
  task automatic give_verdict();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int t, input int lim);
    if (t >= lim) begin
      errors++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      t++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 40);
    s_axi_bready <= 1'b0;
    tmo(t, 40);
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      t++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 40);
    s_axi_rready <= 1'b0;
    tmo(t, 40);
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
  endtask
  task automatic frame(input logic [47:0] da, input logic [15:0] lf, input int n, input bit bad,
    input logic [31:0] flags);
    int s, t;
    s = seen;
    t = 0;
    beats = 0;
    wm_at = -1;
    @(posedge ref_clk);
    phy.send(da, lf, n, bad);
    while (seen == s && t < 100) begin
      @(posedge ref_clk);
      t++;
    end
    tmo(t, 100);
    chk(desc_q & (F_ST | F_HA | F_BC | F_ER | F_DI), flags);
  endtask
  task automatic t_regs();
    rd(OFF_FIFO_THR, 32'h1, RESP_OKAY);
    rd(OFF_PROTECT, 32'h40, RESP_OKAY);
    rd(OFF_STYLE, 32'h0, RESP_OKAY);
    rd(6'h3C, 32'h0, RESP_SLVERR);
    wr(OFF_DESC, 32'h1, RESP_SLVERR);
    wr(OFF_PROTECT, 32'h30, RESP_OKAY);
    rd(OFF_PROTECT, 32'h30, RESP_OKAY);
  endtask
  task automatic t_unicast();
    wr(OFF_STYLE, 32'h1, RESP_OKAY);
    wr(OFF_STA_LO, STA[31:0], RESP_OKAY);
    wr(OFF_STA_HI, {16'h0, STA[47:32]}, RESP_OKAY);
    frame(STA, 16'h002E, 60, 1'b0, F_ST);
    chk(desc_q[15:0], 32'd64);
    frame(STA ^ 48'h0100_0000_0000, 16'h002E, 60, 1'b0, F_DI);
    wr(OFF_MODE, 32'h2000, RESP_OKAY);
    frame(STA, 16'h002E, 60, 1'b0, F_DI);
  endtask
  task automatic t_group();
    wr(OFF_HASH_LO, 32'h0, RESP_OKAY);
    wr(OFF_HASH_HI, 32'h0, RESP_OKAY);
    wr(OFF_MODE, 32'h0, RESP_OKAY);
    frame(48'h1, 16'h002E, 60, 1'b0, F_DI);
    wr(OFF_HASH_LO, 32'hFFFFFFFF, RESP_OKAY);
    wr(OFF_HASH_HI, 32'hFFFFFFFF, RESP_OKAY);
    frame(48'h1, 16'h002E, 60, 1'b0, F_HA);
    frame(BC, 16'h002E, 60, 1'b0, F_BC);
    wr(OFF_MODE, 32'h4000, RESP_OKAY);
    frame(BC, 16'h002E, 60, 1'b0, F_DI);
    wr(OFF_MODE, 32'hE000, RESP_OKAY);
    frame(BC, 16'h002E, 60, 1'b0, 32'h0);
    frame(48'h0202, 16'h002E, 60, 1'b0, 32'h0);
    wr(OFF_MODE, 32'h0, RESP_OKAY);
  endtask
  task automatic t_strip();
    frame(STA, 16'h002E, 60, 1'b1, F_ST | F_ER);
    wr(OFF_FEATURE, 32'h1, RESP_OKAY);
    frame(STA, 16'h000A, 60, 1'b0, F_ST);
    chk(beats, 32'd24);
    chk(b13, 32'h0A);
    frame(STA, 16'h002E, 60, 1'b0, F_ST);
    chk(beats, 32'd64);
    wr(OFF_FEATURE, 32'h0, RESP_OKAY);
    frame(STA, 16'h000A, 60, 1'b0, F_ST);
    chk(beats, 32'd64);
  endtask
  task automatic t_runt();
    frame(STA, 16'h002E, 16, 1'b0, F_DI);
    wr(OFF_TEST, 32'h1, RESP_OKAY);
    frame(STA, 16'h002E, 16, 1'b0, F_ST);
    frame(STA, 16'h002E, 7, 1'b0, F_DI);
    wr(OFF_TEST, 32'h0, RESP_OKAY);
  endtask
  task automatic t_misc();
    wr(OFF_FEATURE, 32'h2, RESP_OKAY);
    @(posedge ref_clk);
    external_reject_n <= 1'b0;
    frame(STA, 16'h002E, 60, 1'b0, F_DI);
    @(posedge ref_clk);
    external_reject_n <= 1'b1;
    frame(48'h0202, 16'h002E, 60, 1'b0, 32'h0);
    wr(OFF_FEATURE, 32'h0, RESP_OKAY);
    wr(OFF_FIFO_THR, 32'h0, RESP_OKAY);
    frame(STA, 16'h002E, 60, 1'b0, F_ST);
    chk(wm_at inside {[15:16]}, 32'h1);
    wr(OFF_STYLE, 32'h0, RESP_OKAY);
    frame(STA, 16'h002E, 60, 1'b0, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_unicast();
    t_group();
    t_strip();
    t_runt();
    t_misc();
    give_verdict();
  end
endmodule
